// ===== verilog/ssp_top.sv
`timescale 1ns/100ps
module ssp_top
    import ssp_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial pins
    input  wire logic        sck_in,
    output logic             sck_out,
    output logic             sck_oe_n,
    input  wire logic        si,
    output logic             so,
    output logic             so_oe_n,
    // Interrupt
    output logic             irq
);

    // Address decode, used by the error answer only
    function automatic logic ssp_mapped(input logic [7:0] a);
        ssp_mapped = (a == SSP_OFF_CTRL) || (a == SSP_OFF_DATA) || (a == SSP_OFF_STAT)
                  || (a == SSP_OFF_MASK) || (a == SSP_OFF_PRESC);
    endfunction

    // Next bit to drive from the shift register
    function automatic logic ssp_head(input logic [7:0] d, input logic lsbf);
        ssp_head = lsbf ? d[0] : d[7];
    endfunction

    // Register state and next values
    // Every register here runs on every clock edge
    logic [7:0]  ctrl;
    logic [7:0]  next_ctrl;
    logic [7:0]  stat;
    logic [7:0]  next_stat;
    logic [7:0]  mask;
    logic [7:0]  next_mask;
    logic [7:0]  presc;
    logic [7:0]  next_presc;
    logic [7:0]  shreg;
    logic [7:0]  next_shreg;
    logic [2:0]  cnt;
    logic [2:0]  next_cnt;
    logic [7:0]  div;
    logic [7:0]  next_div;
    logic        sck_int;
    logic        next_sck_int;
    logic        so_bit;
    logic        next_so_bit;
    logic [31:0] next_prdata;
    logic [7:0]  rd_cap;
    logic [7:0]  next_rd_cap;
    ssp_state_t  state;
    ssp_state_t  next_state;

    // Synchroniser stages and decoded strobes
    logic [2:0]  sck_sync;
    logic [1:0]  si_sync;
    logic        ext_rise;
    logic        ext_fall;
    logic        int_rise;
    logic        int_fall;
    logic        edge_rise;
    logic        edge_fall;
    logic        rx_edge;
    logic        tx_edge;
    logic        div_tick;
    logic        idle_lvl;
    logic        wr_acc;
    logic        rd_acc;
    logic        setup;
    logic        start;
    logic        done;

    // Pin synchronisers; stage 0 feeds only stage 1
    // Shift clock keeps a third stage for edge detection
    // Costs two to three cycles of latency on external edges
    // A false edge after reset is harmless: the port is idle then
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_sync <= 3'h0;
            si_sync  <= 2'h0;
        end else begin
            sck_sync <= {sck_sync[1:0], sck_in};
            si_sync  <= {si_sync[0], si};
        end
    end

    // Bus phases; the slave never stalls
    // Writes land at the end of the access cycle
    // Read data is registered at the setup edge
    // Unmapped offsets answer with an error, no state change
    assign setup   = psel && !penable;
    assign wr_acc  = psel && penable && pwrite;
    assign rd_acc  = psel && penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !ssp_mapped(paddr);

    assign start = wr_acc && (paddr == SSP_OFF_CTRL) && pwdata[SSP_B_START];

    // Shift clock edges from the selected source
    // External edges come from the synchronised copy only
    // Internal edges are the divider ticks themselves
    assign ext_rise  = sck_sync[1] && !sck_sync[2];
    assign ext_fall  = !sck_sync[1] && sck_sync[2];
    assign int_rise  = div_tick && !sck_int;
    assign int_fall  = div_tick && sck_int;
    assign edge_rise = ctrl[SSP_B_CLKSEL] ? ext_rise : int_rise;
    assign edge_fall = ctrl[SSP_B_CLKSEL] ? ext_fall : int_fall;

    // Edge field picks which edge samples and which drives
    assign rx_edge = ctrl[SSP_B_EDGE] ? edge_fall : edge_rise;
    assign tx_edge = ctrl[SSP_B_EDGE] ? edge_rise : edge_fall;

    // Internal clock idles so that its first edge samples
    // Ticks keep running while idle until the level settles
    // Limitation: an edge field change mid-byte is not guarded
    assign idle_lvl = ctrl[SSP_B_EDGE];
    assign div_tick = (div == 8'h00) && ctrl[SSP_B_SHEN]
                   && ((state == SSP_SHIFT) || (sck_int != idle_lvl));

    assign done = (state == SSP_SHIFT) && rx_edge && (cnt == SSP_LAST_BIT);

    // Transfer sequencer next values
    // Eight sample edges make one byte
    // Drive edges only refresh the output bit
    // Restart while busy clears the counter only
    // Data written while busy is dropped, not queued
    always_comb begin
        next_state   = state;
        next_cnt     = cnt;
        next_shreg   = shreg;
        next_so_bit  = so_bit;
        next_sck_int = sck_int;
        next_div     = div;
        // Half period counter, reloaded from the prescaler
        if (!ctrl[SSP_B_SHEN] || ctrl[SSP_B_CLKSEL]) begin
            next_div     = presc;
            next_sck_int = idle_lvl;
        end else if (div_tick) begin
            next_div     = presc;
            next_sck_int = !sck_int;
        end else if (div != 8'h00) begin
            next_div = div - 8'h01;
        end
        // Software may load data only while idle
        if (wr_acc && (paddr == SSP_OFF_DATA) && (state == SSP_IDLE)) begin
            next_shreg  = pwdata[7:0];
            next_so_bit = ssp_head(pwdata[7:0], ctrl[SSP_B_LSBF]);
        end
        case (state)
            SSP_IDLE: begin
                if (start) begin
                    next_cnt    = 3'h0;
                    next_state  = SSP_SHIFT;
                    // Order field of this same write decides the first bit
                    // The old control value would lag by one write
                    next_so_bit = ssp_head(shreg, pwdata[SSP_B_LSBF]);
                    next_div    = presc;
                end
            end
            SSP_SHIFT: begin
                if (start) begin
                    next_cnt = 3'h0;
                end else if (ctrl[SSP_B_SHEN] && rx_edge) begin
                    // Sample, then shift toward the head end
                    if (ctrl[SSP_B_LSBF]) begin
                        next_shreg = {ctrl[SSP_B_TXRX] & si_sync[1], shreg[7:1]};
                    end else begin
                        next_shreg = {shreg[6:0], ctrl[SSP_B_TXRX] & si_sync[1]};
                    end
                    next_cnt = cnt + 3'h1;
                    if (cnt == SSP_LAST_BIT) begin
                        next_state = SSP_IDLE;
                    end
                end else if (ctrl[SSP_B_SHEN] && tx_edge) begin
                    next_so_bit = ssp_head(shreg, ctrl[SSP_B_LSBF]);
                end
            end
            default: begin
                next_state = SSP_IDLE;
            end
        endcase
    end

    // Transfer sequencer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state   <= SSP_IDLE;
            cnt     <= 3'h0;
            shreg   <= SSP_RST_DATA;
            so_bit  <= 1'b1;
            sck_int <= 1'b0;
            div     <= 8'h00;
        end else begin
            state   <= next_state;
            cnt     <= next_cnt;
            shreg   <= next_shreg;
            so_bit  <= next_so_bit;
            sck_int <= next_sck_int;
            div     <= next_div;
        end
    end

    // Register file next values; hardware set wins over software clear
    // Start bit is a strobe and never stored
    // Pending is written like any field, then set by hardware
    // Status clears only through a read of itself
    always_comb begin
        next_ctrl   = ctrl;
        next_stat   = stat;
        next_mask   = mask;
        next_presc  = presc;
        next_rd_cap = rd_cap;
        if (wr_acc) begin
            case (paddr)
                SSP_OFF_CTRL:  next_ctrl  = pwdata[7:0] & ~(8'h01 << SSP_B_START);
                SSP_OFF_MASK:  next_mask  = pwdata[7:0];
                SSP_OFF_PRESC: next_presc = pwdata[7:0];
                default:       next_ctrl  = ctrl;
            endcase
        end
        // Only bits seen by the read are cleared, so a late event survives
        if (rd_acc && (paddr == SSP_OFF_STAT)) begin
            next_stat = stat & ~rd_cap;
        end
        if (done) begin
            next_ctrl[SSP_B_PEND] = 1'b1;
            next_stat[SSP_B_DONE] = 1'b1;
        end
        // Read mux loads at setup and holds through access
        // Upper bits always read as zero
        next_prdata = 32'h0000_0000;
        if (setup && !pwrite) begin
            case (paddr)
                SSP_OFF_CTRL:  next_prdata = {24'h000000, ctrl};
                SSP_OFF_DATA:  next_prdata = {24'h000000, shreg};
                SSP_OFF_STAT:  next_prdata = {24'h000000, stat};
                SSP_OFF_MASK:  next_prdata = {24'h000000, mask};
                SSP_OFF_PRESC: next_prdata = {24'h000000, presc};
                default:       next_prdata = 32'h0000_0000;
            endcase
            next_rd_cap = (paddr == SSP_OFF_STAT) ? stat : 8'h00;
        end else if (!psel) begin
            next_prdata = 32'h0000_0000;
        end else begin
            next_prdata = prdata;
        end
    end

    // Register file registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl   <= SSP_RST_CTRL;
            stat   <= SSP_RST_STAT;
            mask   <= SSP_RST_MASK;
            presc  <= SSP_RST_PRESC;
            rd_cap <= 8'h00;
            prdata <= 32'h0000_0000;
        end else begin
            ctrl   <= next_ctrl;
            stat   <= next_stat;
            mask   <= next_mask;
            presc  <= next_presc;
            rd_cap <= next_rd_cap;
            prdata <= next_prdata;
        end
    end

    // Pin drive; enables are low while driving
    // Clock pin is driven only from the internal source
    // Data pin released while shifting is disabled
    assign sck_out  = sck_int;
    assign sck_oe_n = ctrl[SSP_B_CLKSEL] || !ctrl[SSP_B_SHEN];
    assign so       = so_bit;
    assign so_oe_n  = !ctrl[SSP_B_SHEN];

    // Interrupt gated by the enable bit and the mask
    // Level output; stays high until status is read
    // Clearing the enable hides it without losing status
    assign irq = ctrl[SSP_B_IE] && (|(stat & mask));

endmodule

// ===== verilog/ssp_pkg.sv
package ssp_pkg;
    // Register byte offsets
    localparam logic [7:0] SSP_OFF_CTRL  = 8'h00;
    localparam logic [7:0] SSP_OFF_DATA  = 8'h04;
    localparam logic [7:0] SSP_OFF_STAT  = 8'h08;
    localparam logic [7:0] SSP_OFF_MASK  = 8'h0C;
    localparam logic [7:0] SSP_OFF_PRESC = 8'h10;

    // Control field positions
    localparam int SSP_B_CLKSEL = 7;
    localparam int SSP_B_LSBF   = 6;
    localparam int SSP_B_TXRX   = 5;
    localparam int SSP_B_EDGE   = 4;
    localparam int SSP_B_START  = 3;
    localparam int SSP_B_SHEN   = 2;
    localparam int SSP_B_IE     = 1;
    localparam int SSP_B_PEND   = 0;

    // Status and mask field positions
    localparam int SSP_B_DONE = 0;

    // Reset values
    localparam logic [7:0] SSP_RST_CTRL  = 8'h00;
    localparam logic [7:0] SSP_RST_DATA  = 8'h00;
    localparam logic [7:0] SSP_RST_STAT  = 8'h00;
    localparam logic [7:0] SSP_RST_MASK  = 8'h00;
    localparam logic [7:0] SSP_RST_PRESC = 8'h03;

    // Last count of the 3-bit counter, one less than the 8 bits per transfer
    localparam logic [2:0] SSP_LAST_BIT = 3'h7;

    // Transfer state
    typedef enum logic [1:0] {
        SSP_IDLE  = 2'b01,
        SSP_SHIFT = 2'b10
    } ssp_state_t;
endpackage

// ===== tb/ssp_assertions.sv
`timescale 1ns/100ps
// Pin-level checker, bound onto the top level
module ssp_assertions
    import ssp_pkg::*;
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB side
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // Serial pins and interrupt
    input wire logic        sck_in,
    input wire logic        sck_out,
    input wire logic        sck_oe_n,
    input wire logic        si,
    input wire logic        so,
    input wire logic        so_oe_n,
    input wire logic        irq
);
    logic       wr, edge_r, ie_r, lsb_r;
    logic [7:0] data_r;
    assign wr = psel && penable && pwrite;
    // Shadow of software writes, since control is not visible at the pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {edge_r, ie_r, lsb_r, data_r} <= 11'h000;
        end else if (wr && paddr == SSP_OFF_CTRL) begin
            {edge_r, ie_r, lsb_r} <= {pwdata[SSP_B_EDGE], pwdata[SSP_B_IE], pwdata[SSP_B_LSBF]};
        end else if (wr && paddr == SSP_OFF_DATA) begin
            data_r <= pwdata[7:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Writes may move the idle level, so the cycles after one are skipped
    property p_tx_rise;
        edge_r && !sck_oe_n && !so_oe_n && $changed(so) && !$past(wr) && !$past(wr, 2) |-> $rose(sck_out);
    endproperty
    a_tx_rise: assert property (p_tx_rise) else $error("data moved off a rising clock");
    property p_tx_fall;
        !edge_r && !sck_oe_n && !so_oe_n && $changed(so) && !$past(wr) && !$past(wr, 2) |-> $fell(sck_out);
    endproperty
    a_tx_fall: assert property (p_tx_fall) else $error("data moved off a falling clock");
    property p_first;
        wr && paddr == SSP_OFF_CTRL && pwdata[SSP_B_START] && pwdata[SSP_B_SHEN] |=> so == (lsb_r ? data_r[0] : data_r[7]);
    endproperty
    a_first: assert property (p_first) else $error("first bit wrong");
    property p_irq; irq |-> ie_r || $past(ie_r); endproperty
    a_irq: assert property (p_irq) else $error("interrupt while disabled");
    property p_err; psel && penable |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}); endproperty
    a_err: assert property (p_err) else $error("error response wrong");
    property p_idle_rd; !psel && $past(!psel) |-> prdata == 32'h0; endproperty
    a_idle_rd: assert property (p_idle_rd) else $error("read data outside transfer");
    c_irq: cover property ($rose(irq));
    c_start: cover property (wr && paddr == SSP_OFF_CTRL && pwdata[SSP_B_START]);
    c_err: cover property (pslverr);
endmodule

// ===== tb/ssp_peer.sv
`timescale 1ns/100ps
// Far-side peer: makes the external clock inside frames and swaps a byte
module ssp_peer (
    // Frame control from the bench
    input wire logic       run,
    input wire logic       gen,
    input wire logic       edge_sel,
    input wire logic [7:0] tx,
    // Link as seen at the pins
    input wire logic       sclk,
    input wire logic       so,
    output logic           sck_in,
    output logic           si,
    output logic [7:0]     rx
);
    logic [7:0] sh;
    int         n;
    // Sixteen half periods of 32 ns per frame, then stands at idle
    initial begin
        sck_in = 1'b0;
        n = 0;
        forever begin
            #32;
            if (run && gen && n < 16) begin
                sck_in = ~sck_in;
                n++;
            end else if (!run) begin
                sck_in = edge_sel;
                n = 0;
            end
        end
    end
    // Load at frame start; shift out on tx edges, capture on rx edges
    always @(posedge run) sh = tx;
    always @(sclk) begin
        if (run && sclk == edge_sel) sh = {sh[6:0], 1'b0};
        else if (run) rx = {rx[6:0], so};
    end
    // Outside a frame the line shows no stale bit
    assign si = run ? sh[7] : ~sh[7];
endmodule

// ===== tb/testbench.sv
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; $display("wrong value at %0t: %h", $time, (a)); end end
module testbench;
    import ssp_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0, go = 1'b0;
    logic [7:0]  paddr = 8'h00, tx = 8'h00, ctrl = 8'h00, dat, exp_d, rxp;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, sck_in, sck_out, sck_oe_n, si, so, so_oe_n, irq, err;
    int          fail_count = 0, total_checks = 0, seed = 90, n;
    always #4 pclk = ~pclk;
    ssp_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sck_in(sck_in), .sck_out(sck_out), .sck_oe_n(sck_oe_n), .si(si), .so(so), .so_oe_n(so_oe_n), .irq(irq));
    ssp_peer u_peer (.run(run), .gen(go && ctrl[SSP_B_CLKSEL]), .edge_sel(ctrl[SSP_B_EDGE]),
        .sclk(sck_oe_n ? sck_in : sck_out), .so(so), .tx(tx), .sck_in(sck_in), .si(si), .rx(rxp));
    function automatic logic [7:0] rev(input logic [7:0] v);
        for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
    endfunction
    // One APB transfer; waits for pready, takes data at that edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Random bytes and modes, each with a full completion handshake
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, SSP_OFF_CTRL, 32'h0);
        `CHK(rd[7:0], SSP_RST_CTRL)
        apb(1'b0, SSP_OFF_PRESC, 32'h0);
        `CHK(rd[7:0], SSP_RST_PRESC)
        apb(1'b0, 8'h14, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        apb(1'b1, SSP_OFF_MASK, 32'h1);
        for (int k = 0; k < 8; k++) begin
            ctrl = (8'($random(seed)) & 8'hF2) | 8'h04;
            tx = 8'($random(seed));
            dat = 8'($random(seed));
            apb(1'b1, SSP_OFF_CTRL, {24'h0, ctrl});
            apb(1'b1, SSP_OFF_DATA, {24'h0, dat});
            run <= 1'b1;
            apb(1'b1, SSP_OFF_CTRL, {24'h0, ctrl | 8'h08});
            go <= 1'b1;
            n = 0;
            do begin
                apb(1'b0, SSP_OFF_CTRL, 32'h0);
                n++;
            end while (rd[SSP_B_PEND] !== 1'b1 && n < 60);
            `CHK(rd[SSP_B_PEND], 1'b1)
            `CHK(irq, ctrl[SSP_B_IE])
            `CHK(rxp, ctrl[SSP_B_LSBF] ? rev(dat) : dat)
            exp_d = ctrl[SSP_B_TXRX] ? (ctrl[SSP_B_LSBF] ? rev(tx) : tx) : 8'h00;
            apb(1'b0, SSP_OFF_DATA, 32'h0);
            `CHK(rd[7:0], exp_d)
            apb(1'b0, SSP_OFF_STAT, 32'h0);
            `CHK(rd[0], 1'b1)
            apb(1'b0, SSP_OFF_STAT, 32'h0);
            `CHK(rd[0], 1'b0)
            apb(1'b1, SSP_OFF_CTRL, {24'h0, ctrl});
            apb(1'b0, SSP_OFF_CTRL, 32'h0);
            `CHK(irq, 1'b0)
            `CHK(rd[SSP_B_PEND], 1'b0)
            {run, go} <= 2'b00;
        end
        stop_test();
    end
    // Hang guard
    initial begin
        #100000;
        fail_count++;
        stop_test();
    end
endmodule
bind ssp_top ssp_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .sck_in(sck_in), .sck_out(sck_out), .sck_oe_n(sck_oe_n), .si(si), .so(so), .so_oe_n(so_oe_n), .irq(irq));
